/* src/fault_enable_defines.svh */
// constants for the fault interrupt enable and channel enable bank
`ifndef FAULT_ENABLE_DEFINES_SVH
`define FAULT_ENABLE_DEFINES_SVH

`define OFS_CONTROL_IEN   8'h1B
`define OFS_TEST_IEN      8'h1C
`define OFS_MAKER_IEN     8'h1D
`define OFS_CHAN_EN       8'h1E

`define CTL_IEN_MASK      8'h15
`define TST_IEN_MASK      8'h0B
`define MKR_IEN_MASK      8'hA0
`define CHAN_EN_MASK      8'hFF

`define BIT_RT_CRC        4
`define BIT_TSD           2
`define BIT_PEC           0
`define BIT_SEC           3
`define BIT_BIST_DONE     1
`define BIT_BIST_FAIL     0
`define BIT_STARTUP_CRC   7
`define BIT_RST_MISMATCH  5

`define MKR_IEN_RESET     8'h00
`define CHAN_HI_MASK      8'hF0
`define CHAN_LO_MASK      8'h0F
`define CTL_STRAP_MASK    8'h05

`define CRC8_POLY         8'h07
`define CRC8_INIT         8'h00
`define REG_COUNT         4

`endif

/* src/fault_enable_pkg.sv */
// types for the fault interrupt enable and channel enable bank
package fault_enable_pkg;

  typedef enum logic [1:0] {
    SCAN_IDLE  = 2'b00,
    SCAN_WALK  = 2'b01,
    SCAN_CHECK = 2'b10
  } scan_state_type;

  typedef struct packed {
    logic [7:0] ctl_ien;
    logic [7:0] tst_ien;
    logic [7:0] mkr_ien;
    logic [7:0] chan_en;
  } reg_bank_type;

  typedef struct packed {
    logic runtime_map_check;
    logic thermal_shutdown;
    logic packet_check_error;
    logic single_error_corrected;
    logic self_test_done;
    logic self_test_fail;
    logic startup_self_test_crc;
    logic reset_output_mismatch;
  } fault_type;

  typedef struct packed {
    reg_bank_type   regs;
    scan_state_type scan;
    logic [1:0]     idx;
    logic [7:0]     crc;
    logic [7:0]     ref_crc;
    logic           ref_valid;
    logic           map_error;
    logic           irq_req;
    logic [7:0]     rdata;
    logic [7:0]     chan_out;
    logic           was_rst;
  } state_type;

endpackage

/* src/fault_irq_enable_and_channel_enable.sv */
// fault interrupt enable registers, channel enables and run-time register map check
//
// Notes on behaviour
// - map check runs continuously on its own, no host access needed
// - check uses CRC-8; reference recomputed after any host write changing contents
// - control enable bit 4 maps map check error to interrupt; flag reported
// - control enable bit 2 enables thermal shutdown interrupt
// - control enable bit 0 enables packet check error interrupt
// - test enable bit 3 enables corrected single error interrupt
// - test enable bit 1 enables self test done interrupt
// - test enable bit 0 enables self test fail interrupt
// - maker enable bit 7 maps startup self test CRC fail; resets to 0
// - maker enable bit 5 maps reset output mismatch; resets to 0
// - channel enable bit n-1 enables channel n; channels 5 to 8 reset 0
// - channels 1 to 4 and X bits reset from device configuration input
// - map check detects static bit flips or corruption in stored contents
`timescale 1ns/1ps
`default_nettype none
`include "fault_enable_defines.svh"

module fault_irq_enable_and_channel_enable (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  cfg_reset_value_ctl,
  input  wire logic [7:0]                  cfg_reset_value_tst,
  input  wire logic [7:0]                  cfg_reset_value_chan,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire fault_enable_pkg::fault_type fault_events,
  input  wire logic                        corrupt_inject,
  output logic [7:0]                       reg_rdata,
  output logic [7:0]                       monitor_channel_enable,
  output logic                             map_check_error,
  output logic                             fault_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    c = crc_in ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ `CRC8_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] bank_byte(input fault_enable_pkg::reg_bank_type b, input logic [1:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      2'h0: v = b.ctl_ien;
      2'h1: v = b.tst_ien;
      2'h2: v = b.mkr_ien;
      default: v = b.chan_en;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  fault_enable_pkg::state_type s_q;
  fault_enable_pkg::state_type s_d;
  logic                        changed;
  logic [7:0]                  scan_byte;
  logic [7:0]                  crc_next;
  fault_enable_pkg::reg_bank_type rb;

  always_comb
  begin
    s_d       = s_q;
    s_d.was_rst = 1'b0;
    rb        = s_q.regs;
    changed   = 1'b0;
    scan_byte = 8'h00;
    crc_next  = 8'h00;
    // register writes, reserved bits masked
    if (reg_wr)
    begin
      if (reg_addr == `OFS_CONTROL_IEN)
      begin
        rb.ctl_ien = reg_wdata & `CTL_IEN_MASK;
      end
      else if (reg_addr == `OFS_TEST_IEN)
      begin
        rb.tst_ien = reg_wdata & `TST_IEN_MASK;
      end
      else if (reg_addr == `OFS_MAKER_IEN)
      begin
        rb.mkr_ien = reg_wdata & `MKR_IEN_MASK;
      end
      else if (reg_addr == `OFS_CHAN_EN)
      begin
        rb.chan_en = reg_wdata & `CHAN_EN_MASK;
      end
    end
    changed = (rb != s_q.regs);
    // fault injection flips one stored bit to exercise the check
    if (corrupt_inject)
    begin
      rb.chan_en[0] = ~rb.chan_en[0];
    end
    s_d.regs = rb;
    // read data, unmapped reads give zero
    if (reg_rd)
    begin
      if (reg_addr == `OFS_CONTROL_IEN)
      begin
        s_d.rdata = s_q.regs.ctl_ien;
      end
      else if (reg_addr == `OFS_TEST_IEN)
      begin
        s_d.rdata = s_q.regs.tst_ien;
      end
      else if (reg_addr == `OFS_MAKER_IEN)
      begin
        s_d.rdata = s_q.regs.mkr_ien;
      end
      else if (reg_addr == `OFS_CHAN_EN)
      begin
        s_d.rdata = s_q.regs.chan_en;
      end
      else
      begin
        s_d.rdata = 8'h00;
      end
    end
    // continuous crc scan over the stored bytes
    scan_byte = bank_byte(s_q.regs, s_q.idx);
    crc_next  = crc8_byte(s_q.crc, scan_byte);
    case (s_q.scan)
      fault_enable_pkg::SCAN_IDLE:
      begin
        s_d.scan = fault_enable_pkg::SCAN_WALK;
        s_d.idx  = 2'h0;
        s_d.crc  = `CRC8_INIT;
      end
      fault_enable_pkg::SCAN_WALK:
      begin
        s_d.crc = crc_next;
        s_d.idx = s_q.idx + 2'h1;
        if (s_q.idx == 2'(`REG_COUNT - 1))
        begin
          s_d.scan = fault_enable_pkg::SCAN_CHECK;
        end
      end
      fault_enable_pkg::SCAN_CHECK:
      begin
        if (!s_q.ref_valid)
        begin
          s_d.ref_crc   = s_q.crc;
          s_d.ref_valid = 1'b1;
        end
        else if (s_q.crc != s_q.ref_crc)
        begin
          s_d.map_error = 1'b1;
        end
        s_d.scan = fault_enable_pkg::SCAN_IDLE;
      end
      default:
      begin
        s_d.scan = fault_enable_pkg::SCAN_IDLE;
      end
    endcase
    // host change restarts the scan and rebuilds the reference
    if (changed)
    begin
      s_d.scan      = fault_enable_pkg::SCAN_IDLE;
      s_d.ref_valid = 1'b0;
    end
    s_d.chan_out = s_q.regs.chan_en;
    s_d.irq_req =
      (s_q.map_error                           & s_q.regs.ctl_ien[`BIT_RT_CRC])       |
      (fault_events.runtime_map_check          & s_q.regs.ctl_ien[`BIT_RT_CRC])       |
      (fault_events.thermal_shutdown           & s_q.regs.ctl_ien[`BIT_TSD])          |
      (fault_events.packet_check_error         & s_q.regs.ctl_ien[`BIT_PEC])          |
      (fault_events.single_error_corrected     & s_q.regs.tst_ien[`BIT_SEC])          |
      (fault_events.self_test_done             & s_q.regs.tst_ien[`BIT_BIST_DONE])    |
      (fault_events.self_test_fail             & s_q.regs.tst_ien[`BIT_BIST_FAIL])    |
      (fault_events.startup_self_test_crc      & s_q.regs.mkr_ien[`BIT_STARTUP_CRC])  |
      (fault_events.reset_output_mismatch      & s_q.regs.mkr_ien[`BIT_RST_MISMATCH]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; configuration reset values are caught on the first edge after release

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q.was_rst      <= 1'b1;
      s_q.regs.ctl_ien <= 8'h00;
      s_q.regs.tst_ien <= 8'h00;
      s_q.regs.mkr_ien <= `MKR_IEN_RESET;
      s_q.regs.chan_en <= 8'h00;
      s_q.scan         <= fault_enable_pkg::SCAN_IDLE;
      s_q.idx          <= 2'h0;
      s_q.crc          <= `CRC8_INIT;
      s_q.ref_crc      <= `CRC8_INIT;
      s_q.ref_valid    <= 1'b0;
      s_q.map_error    <= 1'b0;
      s_q.irq_req      <= 1'b0;
      s_q.rdata        <= 8'h00;
      s_q.chan_out     <= 8'h00;
    end
    else if (s_q.was_rst)
    begin
      s_q               <= s_d;
      s_q.regs.ctl_ien  <= cfg_reset_value_ctl & `CTL_STRAP_MASK;
      s_q.regs.tst_ien  <= cfg_reset_value_tst & `TST_IEN_MASK;
      s_q.regs.chan_en  <= cfg_reset_value_chan & `CHAN_LO_MASK & ~`CHAN_HI_MASK;
      s_q.scan          <= fault_enable_pkg::SCAN_IDLE;
      s_q.ref_valid     <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata              = s_q.rdata;
  assign monitor_channel_enable = s_q.chan_out;
  assign map_check_error        = s_q.map_error;
  assign fault_irq              = s_q.irq_req;

endmodule

`default_nettype wire

/* verification/fault_enable_checker.sv */
// concurrent checks on the fault enable bank ports
`timescale 1ns/1ps
`default_nettype none
module fault_enable_checker (
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire fault_enable_pkg::fault_type fault_events,
  input wire logic                        corrupt_inject,
  input wire logic [7:0]                  reg_rdata,
  input wire logic [7:0]                  monitor_channel_enable,
  input wire logic                        map_check_error,
  input wire logic                        fault_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // edges since the last injected corruption
  logic [4:0] since_q;
  always_ff @(posedge mclk)
    if (rst)
      since_q <= 5'h1F;
    else if (corrupt_inject)
      since_q <= 5'h00;
    else if (since_q != 5'h1F)
      since_q <= since_q + 5'h01;
  a_unmapped_reads_zero: assert property (reg_rd && (reg_addr < 8'h1B || reg_addr > 8'h1E) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_reserved_zero: assert property (reg_rd && reg_addr == 8'h1B |=> (reg_rdata & 8'hEA) == 8'h00)
    else $error("control reserved bits set");
  a_tst_reserved_zero: assert property (reg_rd && reg_addr == 8'h1C |=> (reg_rdata & 8'hF4) == 8'h00)
    else $error("test reserved bits set");
  a_irq_quiet: assert property (fault_events == 8'h00 && !map_check_error |=> !fault_irq)
    else $error("interrupt without fault");
  a_error_sticky: assert property (map_check_error |=> map_check_error)
    else $error("map error cleared");
  a_error_has_cause: assert property ($rose(map_check_error) |-> since_q < 5'h10)
    else $error("map error without corruption");
  a_monitor_follows: assert property (reg_wr && reg_addr == 8'h1E && !$past(rst) |=> ##1 monitor_channel_enable == $past(reg_wdata, 2))
    else $error("channel enable output wrong");
  a_reset_outputs_low: assert property ($fell(rst) |-> reg_rdata == 8'h00 && !fault_irq && monitor_channel_enable == 8'h00)
    else $error("outputs not cleared by reset");
  cover property (map_check_error && fault_irq);
  cover property (fault_events != 8'h00 && fault_irq);
  cover property (reg_rd && reg_addr == 8'h1D);
endmodule
bind fault_irq_enable_and_channel_enable fault_enable_checker chk (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .fault_events, .corrupt_inject, .reg_rdata, .monitor_channel_enable, .map_check_error, .fault_irq);
`default_nettype wire

/* verification/host_model.sv */
// host processor issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* verification/fault_irq_enable_and_channel_enable_tb.sv */
// self-checking bench for the fault enable bank
`timescale 1ns/1ps
`default_nettype none
`include "fault_enable_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module fault_irq_enable_and_channel_enable_tb;
  logic                        mclk, rst, reg_wr, reg_rd, corrupt_inject, map_check_error, fault_irq;
  logic [7:0]                  reg_addr, reg_wdata, reg_rdata, mon, cfg_c, cfg_t, cfg_m, a, d, wd;
  fault_enable_pkg::fault_type fault_events;
  logic [15:0]                 seed = 16'hEB3D;
  int                          num_errors = 0;
  int                          cmp_count = 0;
  logic [7:0]                  ofs_tbl [8] = '{8'h1B, 8'h1B, 8'h1B, 8'h1C, 8'h1C, 8'h1C, 8'h1D, 8'h1D};
  int                          bit_tbl [8] = '{4, 2, 0, 3, 1, 0, 7, 5};
  fault_irq_enable_and_channel_enable uut (.mclk, .rst, .cfg_reset_value_ctl(cfg_c), .cfg_reset_value_tst(cfg_t),
    .cfg_reset_value_chan(cfg_m), .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .fault_events, .corrupt_inject,
    .reg_rdata, .monitor_channel_enable(mon), .map_check_error, .fault_irq);
  host_model host (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] mask_of(input logic [7:0] x);
    return x == `OFS_CONTROL_IEN ? `CTL_IEN_MASK : x == `OFS_TEST_IEN ? `TST_IEN_MASK :
           x == `OFS_MAKER_IEN ? `MKR_IEN_MASK : x == `OFS_CHAN_EN ? `CHAN_EN_MASK : 8'h00;
  endfunction
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    num_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    cfg_c = rnd();
    cfg_t = rnd();
    cfg_m = rnd();
    fault_events = '0;
    corrupt_inject = 1'b0;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    host.rd(8'h1B, d); `CHK(d, cfg_c & `CTL_STRAP_MASK)
    host.rd(8'h1C, d); `CHK(d, cfg_t & `TST_IEN_MASK)
    host.rd(8'h1D, d); `CHK(d, 8'h00)
    host.rd(8'h1E, d); `CHK(d, cfg_m & `CHAN_LO_MASK)
    for (int i = 0; i < 40; i++)
    begin
      a = 8'h1A + rnd() % 8'h06;
      wd = rnd();
      host.wr(a, wd);
      host.rd(a, d); `CHK(d, wd & mask_of(a))
    end
    for (int i = 0; i < 3; i++)
      host.wr(8'h1B + 8'(i), 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      fault_events = 8'(8'h80 >> i);
      repeat (2) @(negedge mclk);
      `CHK(fault_irq, 1'b0)
      host.wr(ofs_tbl[i], 8'(8'h01 << bit_tbl[i]));
      @(negedge mclk);
      `CHK(fault_irq, 1'b1)
      fault_events = '0;
      repeat (2) @(negedge mclk);
      `CHK(fault_irq, 1'b0)
      host.wr(ofs_tbl[i], 8'h00);
    end
    wd = rnd();
    host.wr(8'h1E, wd);
    @(negedge mclk);
    `CHK(mon, wd)
    host.wr(8'h1B, 8'h10);
    repeat (20) @(negedge mclk);
    `CHK(map_check_error, 1'b0)
    corrupt_inject = 1'b1;
    @(negedge mclk);
    corrupt_inject = 1'b0;
    repeat (16) @(negedge mclk);
    `CHK(map_check_error, 1'b1)
    `CHK(fault_irq, 1'b1)
    host.wr(8'h1B, 8'h00);
    repeat (2) @(negedge mclk);
    `CHK(fault_irq, 1'b0)
    `CHK(map_check_error, 1'b1)
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    `CHK(map_check_error, 1'b0)
    close_out();
  end
endmodule
`default_nettype wire
